// ===== decoder_defs.vh
// Constants for the instruction operand decoder.
`ifndef DECODER_DEFS_VH
`define DECODER_DEFS_VH
`define REG_CTRL 5'h00
`define REG_STATUS 5'h04
`define REG_WORD 5'h08
`define REG_BANK 5'h0C
`define REG_TPTR 5'h10
`define REG_TLAT 5'h14
`define CTRL_RESET 2'h1
`define CTRL_EN_BIT 0
`define CTRL_XINST_BIT 1
`define BANK_RESET 4'h0
`define TPTR_RESET 21'h000000
`define PHASES_PER_CYCLE 3'h4
`define SECOND_WORD_TAG 4'hF
`define FLAG_C 0
`define FLAG_DC 1
`define FLAG_Z 2
`define FLAG_OV 3
`define FLAG_N 4
`define LIT_NONE 2'h0
`define LIT_8 2'h1
`define LIT_12 2'h2
`define LIT_20 2'h3
`define TBL_KEEP 2'h0
`define TBL_POST_INC 2'h1
`define TBL_POST_DEC 2'h2
`define TBL_PRE_INC 2'h3
`endif

// ===== mcu_instruction_operand_decoder.v
// Instruction operand decoder and instruction cycle timing for an 8-bit core.
`timescale 1ns/100ps
`include "decoder_defs.vh"
// What this block does
// - Instructions are one word, four take two, five with the extended set
// - Destination bit picks accumulator or file register
// - Access bit picks access RAM or bank
// - Three-bit field picks bit zero to seven
// - File operand is address or pointer selector
// - Register moves carry twelve-bit source, destination
// - Lone second word executes as no operation
// - Single word one cycle, taken/jump two
// - Two-word two cycles, three only if taken and relative
// - Instruction cycle is four oscillator periods
// - Table mode: keep, post-inc, post-dec, pre-inc
// - Table pointer 21 bits, latch 8 bits
// - Fast select saves or restores shadow registers
// - Literal is 8, 12 or 20 bits
// - Relative offsets signed, calls use direct address
// - Recognise core and extended instruction groups
// - Arithmetic updates carry, digit, zero, overflow, negative
// - Byte format: opcode, d, a, file address
// - Bit format: opcode, bit number, a, address
module mcu_instruction_operand_decoder (
  input wire core_clk,
  input wire rst_n,
  input wire [4:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire [15:0] fetch_word,
  input wire fetch_valid,
  input wire cond_true,
  input wire [7:0] tbl_rdata,
  output reg decode_valid,
  output reg [15:0] opcode_word,
  output reg two_word,
  output reg is_nop,
  output reg ext_instr,
  output reg dest_to_file,
  output reg [11:0] ram_addr,
  output reg [2:0] bit_sel,
  output reg [1:0] ptr_sel,
  output reg [11:0] src_addr,
  output reg [11:0] dst_addr,
  output reg [19:0] literal,
  output reg [1:0] lit_width,
  output reg [20:0] branch_value,
  output reg branch_rel,
  output reg shadow_save,
  output reg shadow_restore,
  output reg [4:0] flag_mask,
  output reg [1:0] cycles,
  output reg [20:0] table_addr,
  output reg tbl_rd,
  output reg tbl_wr,
  output reg [7:0] table_latch,
  output reg [1:0] phase,
  output reg cycle_pulse,
  output reg busy
);
  reg [1:0] ctrl;
  reg [3:0] bank_select_register;
  reg [20:0] table_pointer;
  reg waiting;
  reg [15:0] first_word;
  reg [1:0] cycles_left;
  reg [15:0] w1;
  reg [15:0] w2;
  reg pair;
  reg take;
  reg lone_second;
  reg d_dest;
  reg [11:0] d_ram;
  reg [11:0] d_src;
  reg [11:0] d_dst;
  reg [19:0] d_lit;
  reg [1:0] d_litw;
  reg [20:0] d_branch;
  reg d_rel;
  reg d_save;
  reg d_restore;
  reg [4:0] d_flags;
  reg d_jump;
  reg d_ext;
  reg d_tblrd;
  reg d_tblwr;
  reg [1:0] d_cycles;
  reg [20:0] next_tptr;
  reg [20:0] next_taddr;

  // Four words open a pair, a fifth with the extended set on; the rest stand alone.
  function needs_second;
    input [15:0] w;
    input xinst;
    begin
      needs_second = (w[15:12] == 4'hC) || (w[15:9] == 7'h76) ||
                     (w[15:8] == 8'hEE && w[7:6] == 2'h0) || (w[15:8] == 8'hEF) ||
                     (xinst && w[15:8] == 8'hEB);
    end
  endfunction

  function is_table_op;
    input [15:0] w;
    begin
      is_table_op = (w[15:3] == 13'h0001);
    end
  endfunction

  always @* begin
    take = fetch_valid && ctrl[`CTRL_EN_BIT];
    pair = waiting;
    w1 = waiting ? first_word : fetch_word;
    w2 = waiting ? fetch_word : 16'h0000;
    lone_second = !waiting && (fetch_word[15:12] == `SECOND_WORD_TAG);
    d_dest = w1[9];
    if (w1[8]) begin
      d_ram = {bank_select_register, w1[7:0]};
    end else begin
      d_ram = {4'h0, w1[7:0]};
    end
    d_src = w1[11:0];
    d_dst = w2[11:0];
    d_lit = 20'h00000;
    d_litw = `LIT_NONE;
    d_branch = 21'h000000;
    d_rel = 1'b0;
    d_save = 1'b0;
    d_restore = 1'b0;
    d_flags = 5'h00;
    d_jump = 1'b0;
    d_ext = 1'b0;
    d_tblrd = 1'b0;
    d_tblwr = 1'b0;
    case (w1[15:12])
      4'h0: begin
        if (w1[11:8] == 4'hE || w1[11:8] == 4'hF || w1[11:8] == 4'h9 ||
            w1[11:8] == 4'hB || w1[11:8] == 4'hA || w1[11:8] == 4'h8 ||
            w1[11:8] == 4'hD || w1[11:8] == 4'hC) begin
          d_lit = {12'h000, w1[7:0]};
          d_litw = `LIT_8;
        end
        if (w1[15:1] == 15'h0009 || w1[15:1] == 15'h0008) begin
          d_restore = w1[0];
          d_jump = 1'b1;
        end
        if (ctrl[`CTRL_XINST_BIT] && w1 == 16'h0014) begin
          d_ext = 1'b1;
          d_jump = 1'b1;
        end
        d_tblrd = is_table_op(w1) && !w1[2];
        d_tblwr = is_table_op(w1) && w1[2];
        case (w1[15:10])
          6'h01: d_flags = 5'h1F;
          6'h04, 6'h05, 6'h07: d_flags = (5'h1 << `FLAG_Z) | (5'h1 << `FLAG_N);
          default: begin
          end
        endcase
      end
      4'h1, 4'h2, 4'h3, 4'h4, 4'h5: begin
        case (w1[15:10])
          6'h08, 6'h09, 6'h0A, 6'h0B, 6'h0E, 6'h0F, 6'h16, 6'h17: d_flags = 5'h1F;
          6'h04, 6'h05, 6'h06, 6'h07, 6'h14: begin
            d_flags = (5'h1 << `FLAG_Z) | (5'h1 << `FLAG_N);
          end
          default: d_flags = 5'h00;
        endcase
      end
      4'h6: begin
        if (w1[11:9] == 3'h5) begin
          d_flags = 5'h1 << `FLAG_Z;
        end
      end
      4'hD: begin
        d_branch = {{10{w1[10]}}, w1[10:0]};
        d_rel = 1'b1;
        d_jump = 1'b1;
      end
      4'hE: begin
        if (w1[11] == 1'b0) begin
          d_branch = {{13{w1[7]}}, w1[7:0]};
          d_rel = 1'b1;
        end else if (w1[11:9] == 3'h6 || w1[11:8] == 4'hF) begin
          d_branch = {1'b0, w2[11:0], w1[7:0]};
          d_lit = {w2[11:0], w1[7:0]};
          d_litw = `LIT_20;
          d_save = (w1[11:9] == 3'h6) && w1[8];
          d_jump = 1'b1;
        end else if (w1[11:8] == 4'hE) begin
          d_lit = {8'h00, w1[3:0], w2[7:0]};
          d_litw = `LIT_12;
        end else if (ctrl[`CTRL_XINST_BIT]) begin
          d_ext = 1'b1;
          d_lit = {12'h000, w1[7:0]};
          d_litw = `LIT_8;
        end
      end
      default: begin
      end
    endcase
    // Only two-word instructions reach the three-cycle case; conditional ones stay at two.
    if (pair) begin
      d_cycles = (cond_true && d_rel) ? 2'h3 : 2'h2;
    end else if (cond_true || d_jump) begin
      d_cycles = 2'h2;
    end else begin
      d_cycles = 2'h1;
    end
    next_tptr = table_pointer;
    next_taddr = table_pointer;
    case (w1[1:0])
      `TBL_POST_INC: next_tptr = table_pointer + 21'h000001;
      `TBL_POST_DEC: next_tptr = table_pointer - 21'h000001;
      `TBL_PRE_INC: begin
        next_tptr = table_pointer + 21'h000001;
        next_taddr = next_tptr;
      end
      default: next_tptr = table_pointer;
    endcase
  end

  always @(posedge core_clk) begin
    if (!rst_n) begin
      phase <= 2'h0;
      cycle_pulse <= 1'b0;
    end else begin
      phase <= phase + 2'h1;
      cycle_pulse <= (phase == `PHASES_PER_CYCLE - 3'h2);
    end
  end

  always @(posedge core_clk) begin
    if (!rst_n) begin
      waiting <= 1'b0;
      first_word <= 16'h0000;
      decode_valid <= 1'b0;
      opcode_word <= 16'h0000;
      two_word <= 1'b0;
      is_nop <= 1'b0;
      ext_instr <= 1'b0;
      dest_to_file <= 1'b0;
      ram_addr <= 12'h000;
      bit_sel <= 3'h0;
      ptr_sel <= 2'h0;
      src_addr <= 12'h000;
      dst_addr <= 12'h000;
      literal <= 20'h00000;
      lit_width <= `LIT_NONE;
      branch_value <= 21'h000000;
      branch_rel <= 1'b0;
      shadow_save <= 1'b0;
      shadow_restore <= 1'b0;
      flag_mask <= 5'h00;
      cycles <= 2'h0;
      table_addr <= 21'h000000;
      tbl_rd <= 1'b0;
      tbl_wr <= 1'b0;
      cycles_left <= 2'h0;
      busy <= 1'b0;
    end else begin
      decode_valid <= 1'b0;
      shadow_save <= 1'b0;
      shadow_restore <= 1'b0;
      tbl_rd <= 1'b0;
      tbl_wr <= 1'b0;
      if (cycle_pulse && cycles_left != 2'h0) begin
        cycles_left <= cycles_left - 2'h1;
        busy <= (cycles_left != 2'h1);
      end
      if (take && !waiting && needs_second(fetch_word, ctrl[`CTRL_XINST_BIT])) begin
        waiting <= 1'b1;
        first_word <= fetch_word;
      end else if (take) begin
        waiting <= 1'b0;
        decode_valid <= 1'b1;
        opcode_word <= w1;
        two_word <= pair;
        is_nop <= lone_second;
        ext_instr <= d_ext && !lone_second;
        dest_to_file <= d_dest;
        ram_addr <= d_ram;
        bit_sel <= w1[11:9];
        ptr_sel <= w1[5:4];
        src_addr <= d_src;
        dst_addr <= d_dst;
        literal <= lone_second ? 20'h00000 : d_lit;
        lit_width <= lone_second ? `LIT_NONE : d_litw;
        branch_value <= d_branch;
        branch_rel <= d_rel && !lone_second;
        shadow_save <= d_save && !lone_second;
        shadow_restore <= d_restore && !lone_second;
        flag_mask <= lone_second ? 5'h00 : d_flags;
        cycles <= lone_second ? 2'h1 : d_cycles;
        cycles_left <= lone_second ? 2'h1 : d_cycles;
        busy <= 1'b1;
        table_addr <= next_taddr;
        tbl_rd <= d_tblrd && !lone_second;
        tbl_wr <= d_tblwr && !lone_second;
      end
    end
  end

  // The table read result lands one cycle after the read pulse.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl <= `CTRL_RESET;
      bank_select_register <= `BANK_RESET;
      table_pointer <= `TPTR_RESET;
      table_latch <= 8'h00;
      reg_rdata <= 32'h00000000;
    end else begin
      if (tbl_rd) begin
        table_latch <= tbl_rdata;
      end
      if (take && !waiting && !lone_second && is_table_op(fetch_word)) begin
        table_pointer <= next_tptr;
      end
      if (reg_wr) begin
        case (reg_addr)
          `REG_CTRL: ctrl <= reg_wdata[1:0];
          `REG_BANK: bank_select_register <= reg_wdata[3:0];
          `REG_TPTR: table_pointer <= reg_wdata[20:0];
          `REG_TLAT: table_latch <= reg_wdata[7:0];
          default: begin
          end
        endcase
      end
      reg_rdata <= 32'h00000000;
      if (reg_rd) begin
        case (reg_addr)
          `REG_CTRL: reg_rdata <= {30'h00000000, ctrl};
          `REG_STATUS: reg_rdata <= {24'h000000, cycles_left, cycles, waiting, two_word,
                                     busy, is_nop};
          `REG_WORD: reg_rdata <= {first_word, opcode_word};
          `REG_BANK: reg_rdata <= {28'h0000000, bank_select_register};
          `REG_TPTR: reg_rdata <= {11'h000, table_pointer};
          `REG_TLAT: reg_rdata <= {24'h000000, table_latch};
          default: reg_rdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

// ===== decoder_properties.sv
// Assertions on the decoder outputs.
`timescale 1ns/100ps
module decoder_properties (
  input wire core_clk,
  input wire rst_n,
  input wire decode_valid,
  input wire [15:0] opcode_word,
  input wire two_word,
  input wire is_nop,
  input wire dest_to_file,
  input wire [2:0] bit_sel,
  input wire shadow_save,
  input wire shadow_restore,
  input wire [1:0] cycles,
  input wire [1:0] phase,
  input wire cycle_pulse,
  input wire busy
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  wire one = decode_valid && !two_word && !is_nop;
  phase_step_a: assert property (phase != 2'h3 |=> phase == $past(phase) + 2'h1)
    else $error("phase stalled");
  phase_wrap_a: assert property (phase == 2'h3 |=> phase == 2'h0)
    else $error("phase missed wrap");
  dest_bit_a: assert property (one |-> dest_to_file == opcode_word[9])
    else $error("bad destination");
  bit_num_a: assert property (one |-> bit_sel == opcode_word[11:9])
    else $error("bad bit number");
  single_len_a: assert property (one |-> cycles == 2'h1 || cycles == 2'h2)
    else $error("bad single cycles");
  pair_len_a: assert property (decode_valid && two_word |-> cycles[1])
    else $error("bad pair cycles");
  lone_nop_a: assert property (decode_valid && is_nop |-> cycles == 2'h1 && !two_word)
    else $error("bad lone word");
  shadow_sync_a: assert property (shadow_save || shadow_restore |-> decode_valid)
    else $error("stray shadow pulse");
  cycle_mark_a: assert property (cycle_pulse == (phase == 2'h3))
    else $error("cycle pulse out of phase");
  busy_set_a: assert property (decode_valid |-> busy)
    else $error("busy missing at decode");
  pair_c: cover property (decode_valid && two_word);
  nop_c: cover property (decode_valid && is_nop);
  shadow_c: cover property (shadow_save);
endmodule
bind mcu_instruction_operand_decoder decoder_properties props (.core_clk, .rst_n,
  .decode_valid, .opcode_word, .two_word, .is_nop, .dest_to_file, .bit_sel,
  .shadow_save, .shadow_restore, .cycles, .phase, .cycle_pulse, .busy);

// ===== prog_mem_model.sv
// Program memory model that hands instruction words and table bytes to the decoder.
`timescale 1ns/100ps
module prog_mem_model (
  input wire core_clk,
  input wire req,
  input wire [15:0] word,
  input wire cond,
  input wire [20:0] table_addr,
  input wire tbl_rd,
  output reg [15:0] fetch_word = 16'h0,
  output reg fetch_valid = 1'b0,
  output reg cond_true = 1'b0,
  output wire [7:0] tbl_rdata
);
  // Idle lines show inverted values, so a stale word can never decode by luck.
  always @(posedge core_clk) begin
    fetch_valid <= req;
    fetch_word <= req ? word : ~fetch_word;
    cond_true <= req ? cond : ~cond_true;
  end
  assign tbl_rdata = table_addr[7:0] ^ (tbl_rd ? 8'hA5 : 8'h5A);
endmodule

// ===== tb_top.sv
// Self-checking bench for the instruction operand decoder.
`timescale 1ns/100ps
`include "decoder_defs.vh"
module tb_top;
  reg core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, req = 1'b0, cond = 1'b0;
  reg [4:0] reg_addr = 5'h00;
  reg [31:0] reg_wdata = 32'h0;
  reg [15:0] word = 16'h0;
  reg [20:0] p, a;
  integer error_cnt = 0, num_checks = 0, i, n;
  wire [31:0] reg_rdata;
  wire [15:0] fetch_word, opcode_word;
  wire [7:0] tbl_rdata, table_latch;
  wire [11:0] ram_addr, src_addr, dst_addr;
  wire [19:0] literal;
  wire [20:0] branch_value, table_addr;
  wire [4:0] flag_mask;
  wire [2:0] bit_sel;
  wire [1:0] ptr_sel, lit_width, cycles, phase;
  wire fetch_valid, cond_true, decode_valid, two_word, is_nop, ext_instr, dest_to_file;
  wire branch_rel, shadow_save, shadow_restore, tbl_rd, tbl_wr, cycle_pulse, busy;
  mcu_instruction_operand_decoder dut (.*);
  prog_mem_model mem (.*);
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[ERR] %0t got %0h want %0h", $time, seen, exp);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task acc(input w, input [4:0] ad, input [31:0] d);
    begin
      @(posedge core_clk);
      reg_wr <= w;
      reg_rd <= !w;
      reg_addr <= ad;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1;
    end
  endtask
  // The wait covers the longest instruction, three cycles of four periods each.
  task ft(input [15:0] w1, input [15:0] w2, input c);
    begin
      repeat (13) @(posedge core_clk);
      req <= 1'b1;
      word <= w1;
      cond <= c;
      if (w2 != 16'h0) begin
        @(posedge core_clk);
        word <= w2;
      end
      @(posedge core_clk);
      req <= 1'b0;
      for (n = 0; n < 8 && decode_valid !== 1'b1; n = n + 1)
        @(posedge core_clk) #1;
      chk(decode_valid, 1'h1);
    end
  endtask
  initial begin
    #50000;
    error_cnt = error_cnt + 1;
    give_verdict;
  end
  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    acc(1'h0, `REG_CTRL, 32'h0);
    chk(reg_rdata, 32'h1);
    acc(1'h0, 5'h18, 32'h0);
    chk(reg_rdata, 32'h0);
    acc(1'h1, `REG_BANK, 32'h3);
    ft(16'h27A5, 16'h0, 1'h0);
    chk(dest_to_file, 1'h1);
    chk(ram_addr, 12'h3A5);
    chk(flag_mask, 5'h1F);
    chk(cycles, 2'h1);
    ft(16'h2455, 16'h0, 1'h0);
    chk(dest_to_file, 1'h0);
    chk(ram_addr, 12'h055);
    for (i = 0; i < 8; i = i + 1) begin
      ft({4'h8, i[2:0], 9'h112}, 16'h0, 1'h0);
      chk(bit_sel, i);
    end
    $display("file operand test done");
    ft(16'h0E7F, 16'h0, 1'h0);
    chk(literal, 20'h0007F);
    chk(lit_width, `LIT_8);
    ft(16'hEE2F, 16'hF0AB, 1'h0);
    chk(ptr_sel, 2'h2);
    chk(lit_width, `LIT_12);
    ft(16'hEF12, 16'hF345, 1'h0);
    chk(two_word, 1'h1);
    chk(literal, 20'h34512);
    chk(cycles, 2'h2);
    chk(branch_rel, 1'h0);
    chk(busy, 1'h1);
    ft(16'hC123, 16'hF456, 1'h0);
    chk(src_addr, 12'h123);
    chk(dst_addr, 12'h456);
    acc(1'h0, `REG_WORD, 32'h0);
    chk(reg_rdata, 32'hC123C123);
    ft(16'hF123, 16'h0, 1'h0);
    chk(is_nop, 1'h1);
    $display("literal and two-word test done");
    ft(16'hED12, 16'hF345, 1'h0);
    chk(shadow_save, 1'h1);
    ft(16'hEC12, 16'hF345, 1'h0);
    chk(shadow_save, 1'h0);
    ft(16'h0011, 16'h0, 1'h0);
    chk(shadow_restore, 1'h1);
    chk(cycles, 2'h2);
    ft(16'hE2F0, 16'h0, 1'h1);
    chk(branch_value, 21'h1FFFF0);
    chk(branch_rel, 1'h1);
    chk(cycles, 2'h2);
    ft(16'hE805, 16'h0, 1'h0);
    chk(ext_instr, 1'h0);
    acc(1'h1, `REG_CTRL, 32'h3);
    ft(16'hE805, 16'h0, 1'h0);
    chk(ext_instr, 1'h1);
    $display("control test done");
    p = 21'h1FFFFF;
    acc(1'h1, `REG_TPTR, {11'h0, p});
    for (i = 0; i < 4; i = i + 1) begin
      a = (i == 3) ? p + 21'h1 : p;
      p = (i == 2) ? p - 21'h1 : (i == 0) ? p : p + 21'h1;
      ft({14'h2, i[1:0]}, 16'h0, 1'h0);
      chk(table_addr, a);
      acc(1'h0, `REG_TPTR, 32'h0);
      chk(reg_rdata, p);
      chk(table_latch, a[7:0] ^ 8'hA5);
    end
    ft(16'h000C, 16'h0, 1'h0);
    chk(tbl_wr, 1'h1);
    chk(tbl_rd, 1'h0);
    $display("table pointer test done");
    give_verdict;
  end
endmodule
